// ==== rtl/crs_pkg.sv ====
`default_nettype none

package crs_pkg;

  // channel and stage geometry
  localparam int CRS_NUM_CH = 32;
  localparam int CRS_IDX_W = 5;
  localparam int CRS_WORD_W = CRS_IDX_W + 1;
  localparam int CRS_FIFO_DEPTH = 16;
  localparam int CRS_SYNC_STAGES = 2;

  // field positions in a channel event word
  localparam int CRS_WORD_IDX_LSB = 0;
  localparam int CRS_WORD_TEST_BIT = CRS_IDX_W;

  // values after reset
  localparam logic [CRS_NUM_CH-1:0] CRS_SEL_RST = 32'h0000_0000;
  localparam logic CRS_BIT_RST = 1'h0;
  localparam logic [CRS_IDX_W-1:0] CRS_IDX_RST = 5'h00;

  // controller timing, kept for reference by both sides
  localparam int CRS_CLK_PERIOD_NS = 50;
  localparam int CRS_HOLD_DELAY_NS = 500;
  localparam int CRS_HOLD_DELAY_CYC =
    (CRS_HOLD_DELAY_NS + CRS_CLK_PERIOD_NS - 1) / CRS_CLK_PERIOD_NS;

  typedef enum logic [1:0] {
    CRS_IDLE,
    CRS_ACTIVE,
    CRS_EXIT
  } crs_state_t;

endpackage : crs_pkg

`default_nettype wire

// ==== rtl/crs_sync.sv ====
`default_nettype none

module crs_sync
  import crs_pkg::*;
#(
  parameter int WIDTH = 1
)
(
  input wire logic i_mclk,              // system clock
  input wire logic i_rst,               // synchronous reset
  input wire logic [WIDTH-1:0] i_async, // pin levels
  output logic [WIDTH-1:0] o_sync       // synchronised levels
);

  initial
  begin
    if (WIDTH < 1)
    begin
      $error("crs_sync: WIDTH must be at least 1");
    end
  end

  logic [WIDTH-1:0] meta_ff;
  logic [WIDTH-1:0] sync_ff;
  logic [WIDTH-1:0] nxt_meta;
  logic [WIDTH-1:0] nxt_sync;

  always_comb
  begin
    nxt_meta = i_rst ? {WIDTH{CRS_BIT_RST}} : i_async;
    nxt_sync = i_rst ? {WIDTH{CRS_BIT_RST}} : meta_ff;
  end

  always_ff @(posedge i_mclk)
  begin
    meta_ff <= nxt_meta;
    sync_ff <= nxt_sync;
  end

  assign o_sync = sync_ff;

endmodule : crs_sync

`default_nettype wire

// ==== rtl/crs_fifo.sv ====
`default_nettype none

module crs_fifo
  import crs_pkg::*;
#(
  parameter int WIDTH = CRS_WORD_W,
  parameter int DEPTH = CRS_FIFO_DEPTH
)
(
  input wire logic i_mclk,              // system clock
  input wire logic i_rst,               // synchronous reset
  input wire logic i_in_valid,          // write request
  output logic o_in_ready,              // space available
  input wire logic [WIDTH-1:0] i_in_data, // write word
  output logic o_out_valid,             // word available
  input wire logic i_out_ready,         // reader takes word
  output logic [WIDTH-1:0] o_out_data   // head word
);

  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam logic [AW:0] DEPTH_C = (AW + 1)'(DEPTH);
  localparam logic [AW-1:0] LAST_C = AW'(DEPTH - 1);

  initial
  begin
    if (WIDTH < 1 || DEPTH < 2)
    begin
      $error("crs_fifo: WIDTH >= 1 and DEPTH >= 2 required");
    end
  end

  logic [WIDTH-1:0] mem_ff [DEPTH];
  logic [AW-1:0] wr_ff;
  logic [AW-1:0] rd_ff;
  logic [AW:0] cnt_ff;
  logic [AW-1:0] nxt_wr;
  logic [AW-1:0] nxt_rd;
  logic [AW:0] nxt_cnt;
  logic push;
  logic pop;

  always_comb
  begin
    push = i_in_valid && o_in_ready;
    pop = o_out_valid && i_out_ready;
    nxt_wr = wr_ff;
    nxt_rd = rd_ff;
    nxt_cnt = cnt_ff;
    if (push)
    begin
      nxt_wr = (wr_ff == LAST_C) ? '0 : wr_ff + 1'b1;
    end
    if (pop)
    begin
      nxt_rd = (rd_ff == LAST_C) ? '0 : rd_ff + 1'b1;
    end
    if (push && !pop)
    begin
      nxt_cnt = cnt_ff + 1'b1;
    end
    else if (pop && !push)
    begin
      nxt_cnt = cnt_ff - 1'b1;
    end
    if (i_rst)
    begin
      nxt_wr = '0;
      nxt_rd = '0;
      nxt_cnt = '0;
    end
  end

  always_ff @(posedge i_mclk)
  begin
    wr_ff <= nxt_wr;
    rd_ff <= nxt_rd;
    cnt_ff <= nxt_cnt;
    if (push)
    begin
      mem_ff[wr_ff] <= i_in_data;
    end
  end

  assign o_in_ready = (cnt_ff != DEPTH_C);
  assign o_out_valid = (cnt_ff != '0);
  assign o_out_data = mem_ff[rd_ff];

endmodule : crs_fifo

`default_nettype wire

// ==== rtl/crs_readout_seq.sv ====
`default_nettype none

module crs_readout_seq
  import crs_pkg::*;
#(
  parameter int NUM_CH = CRS_NUM_CH,
  parameter int FIFO_DEPTH = CRS_FIFO_DEPTH
)
(
  input wire logic i_mclk,                  // system clock, 20 MHz
  input wire logic i_rst,                   // synchronous reset
  input wire logic i_logic_clear,           // pin: clear digital section
  input wire logic i_sample_freeze,         // pin: sample-hold strobe
  input wire logic i_token_inject,          // pin: start token
  input wire logic i_shift_strobe,          // pin: readout shift clock
  input wire logic i_readout_strobe_compl,  // pin: complement of shift clk
  input wire logic i_test_select,           // pin: test mode select
  input wire logic i_chan_ready,            // digitiser takes event word
  output logic [NUM_CH-1:0] o_out_sel,      // output mux selects
  output logic [NUM_CH-1:0] o_cal_sel,      // calibration mux selects
  output logic o_token_exit,                // end of readout token
  output logic o_sample_hold,               // samples frozen
  output logic o_test_mode,                 // test mode active
  output logic o_shift_stall,               // shift waits for space
  output logic o_chan_valid,                // event word valid
  output logic [CRS_IDX_W-1:0] o_chan_idx,  // selected channel index
  output logic o_chan_test                  // event taken in test mode
);

  initial
  begin
    if (NUM_CH != (1 << CRS_IDX_W))
    begin
      $error("crs_readout_seq: NUM_CH must equal 2**CRS_IDX_W");
    end
    if (FIFO_DEPTH < 2)
    begin
      $error("crs_readout_seq: FIFO_DEPTH must be at least 2");
    end
  end

  // ---- pin synchronisers
  logic [5:0] pin_sync;
  logic clear_s;
  logic freeze_s;
  logic token_s;
  logic shift_lvl_s;
  logic test_s;

  // both shift pins are synced apart, the level is formed after the flops
  crs_sync #(
    .WIDTH(6)
  ) u_sync (
    .i_mclk(i_mclk),
    .i_rst(i_rst),
    .i_async({i_logic_clear,
              i_sample_freeze,
              i_token_inject,
              i_shift_strobe,
              i_readout_strobe_compl,
              i_test_select}),
    .o_sync(pin_sync)
  );

  assign clear_s = pin_sync[5];
  assign freeze_s = pin_sync[4];
  assign token_s = pin_sync[3];
  assign shift_lvl_s = pin_sync[2] & ~pin_sync[1];
  assign test_s = pin_sync[0];

  // ---- state
  crs_state_t state_ff;
  crs_state_t nxt_state;
  logic [NUM_CH-1:0] out_tok_ff;
  logic [NUM_CH-1:0] nxt_out_tok;
  logic [NUM_CH-1:0] cal_tok_ff;
  logic [NUM_CH-1:0] nxt_cal_tok;
  logic [NUM_CH-1:0] out_sel_ff;
  logic [NUM_CH-1:0] nxt_out_sel;
  logic [NUM_CH-1:0] cal_sel_ff;
  logic [NUM_CH-1:0] nxt_cal_sel;
  logic shift_lvl_ff;
  logic nxt_shift_lvl;
  logic pend_ff;
  logic nxt_pend;
  logic pend_tok_ff;
  logic nxt_pend_tok;
  logic exit_ff;
  logic nxt_exit;
  logic hold_ff;
  logic nxt_hold;
  logic test_ff;
  logic nxt_test;
  logic stall_ff;
  logic nxt_stall;

  logic wipe;
  logic shift_edge;
  logic do_shift;
  logic inject;
  logic pass_done;
  logic [CRS_IDX_W-1:0] sel_idx;

  // fifo wiring
  logic fifo_in_ready;
  logic fifo_in_valid;
  logic [CRS_WORD_W-1:0] fifo_in_data;
  logic fifo_out_valid;
  logic fifo_out_ready;
  logic [CRS_WORD_W-1:0] fifo_out_data;
  logic ev_valid_ff;
  logic nxt_ev_valid;
  logic [CRS_WORD_W-1:0] ev_word_ff;
  logic [CRS_WORD_W-1:0] nxt_ev_word;

  function automatic logic [CRS_IDX_W-1:0] onehot_idx(
    input logic [NUM_CH-1:0] vec
  );
    logic [CRS_IDX_W-1:0] idx;
    idx = CRS_IDX_RST;
    for (int k = 0; k < NUM_CH; k++)
    begin
      if (vec[k])
      begin
        idx = CRS_IDX_W'(k);
      end
    end
    return idx;
  endfunction : onehot_idx

  // ---- control
  always_comb
  begin
    wipe = i_rst || clear_s;
    shift_edge = shift_lvl_s && !shift_lvl_ff;
    // a shift waits while the event fifo is full
    do_shift = pend_ff && fifo_in_ready;
    // a second token is refused while one is in the register
    inject = do_shift && pend_tok_ff && (out_tok_ff == '0);
    pass_done = do_shift && out_tok_ff[NUM_CH-1];
    nxt_shift_lvl = wipe ? CRS_BIT_RST : shift_lvl_s;
    // a new edge in the shifting cycle keeps the request alive
    nxt_pend = shift_edge || (pend_ff && !do_shift);
    nxt_pend_tok = shift_edge ? token_s : pend_tok_ff;
    nxt_hold = freeze_s;
    nxt_test = test_s;
    nxt_stall = pend_ff && !fifo_in_ready;
    nxt_exit = exit_ff;
    if (do_shift)
    begin
      // level lasts one shift period so the next chip samples it
      nxt_exit = out_tok_ff[NUM_CH-1];
    end
    nxt_state = state_ff;
    case (state_ff)
      CRS_IDLE:
      begin
        if (inject)
        begin
          nxt_state = CRS_ACTIVE;
        end
      end
      CRS_ACTIVE:
      begin
        if (pass_done)
        begin
          nxt_state = CRS_EXIT;
        end
      end
      CRS_EXIT:
      begin
        // exit token drops on the next shift: back to idle, or to active if a token is injected
        if (do_shift)
        begin
          nxt_state = inject ? CRS_ACTIVE : CRS_IDLE;
        end
      end
      default:
      begin
        nxt_state = CRS_IDLE;
      end
    endcase
    if (wipe)
    begin
      nxt_pend = CRS_BIT_RST;
      nxt_pend_tok = CRS_BIT_RST;
      nxt_exit = CRS_BIT_RST;
      nxt_hold = CRS_BIT_RST;
      nxt_test = CRS_BIT_RST;
      nxt_stall = CRS_BIT_RST;
      nxt_state = CRS_IDLE;
    end
  end

  // ---- token registers, one stage per channel
  genvar g;
  generate
    for (g = 0; g < NUM_CH; g++)
    begin : g_stage
      always_comb
      begin
        nxt_out_tok[g] = out_tok_ff[g];
        nxt_cal_tok[g] = cal_tok_ff[g];
        if (do_shift)
        begin
          if (g == 0)
          begin
            nxt_out_tok[g] = inject;
            nxt_cal_tok[g] = inject;
          end
          else
          begin
            nxt_out_tok[g] = out_tok_ff[g-1];
            nxt_cal_tok[g] = cal_tok_ff[g-1];
          end
        end
        if (wipe)
        begin
          nxt_out_tok[g] = CRS_SEL_RST[g];
          nxt_cal_tok[g] = CRS_SEL_RST[g];
        end
        nxt_out_sel[g] = nxt_out_tok[g];
        // cal switch only with its twin output switch closed
        nxt_cal_sel[g] = nxt_cal_tok[g] && nxt_out_tok[g]
                         && nxt_test;
      end
    end
  endgenerate

  always_ff @(posedge i_mclk)
  begin
    state_ff <= nxt_state;
    out_tok_ff <= nxt_out_tok;
    cal_tok_ff <= nxt_cal_tok;
    out_sel_ff <= nxt_out_sel;
    cal_sel_ff <= nxt_cal_sel;
    shift_lvl_ff <= nxt_shift_lvl;
    pend_ff <= nxt_pend;
    pend_tok_ff <= nxt_pend_tok;
    exit_ff <= nxt_exit;
    hold_ff <= nxt_hold;
    test_ff <= nxt_test;
    stall_ff <= nxt_stall;
  end

  // ---- event stream: one word per channel put on the output
  always_comb
  begin
    sel_idx = onehot_idx(nxt_out_tok);
    fifo_in_valid = do_shift && (nxt_out_tok != '0) && !wipe;
    fifo_in_data = {test_ff, sel_idx};
  end

  crs_fifo #(
    .WIDTH(CRS_WORD_W),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .i_mclk(i_mclk),
    .i_rst(wipe),
    .i_in_valid(fifo_in_valid),
    .o_in_ready(fifo_in_ready),
    .i_in_data(fifo_in_data),
    .o_out_valid(fifo_out_valid),
    .i_out_ready(fifo_out_ready),
    .o_out_data(fifo_out_data)
  );

  // output register so the stream ports come from flops
  always_comb
  begin
    fifo_out_ready = !ev_valid_ff || i_chan_ready;
    nxt_ev_valid = ev_valid_ff;
    nxt_ev_word = ev_word_ff;
    if (fifo_out_ready)
    begin
      nxt_ev_valid = fifo_out_valid;
      nxt_ev_word = fifo_out_valid ? fifo_out_data : ev_word_ff;
    end
    if (wipe)
    begin
      nxt_ev_valid = CRS_BIT_RST;
      nxt_ev_word = '0;
    end
  end

  always_ff @(posedge i_mclk)
  begin
    ev_valid_ff <= nxt_ev_valid;
    ev_word_ff <= nxt_ev_word;
  end

  assign o_out_sel = out_sel_ff;
  assign o_cal_sel = cal_sel_ff;
  assign o_token_exit = exit_ff;
  assign o_sample_hold = hold_ff;
  assign o_test_mode = test_ff;
  assign o_shift_stall = stall_ff;
  assign o_chan_valid = ev_valid_ff;
  assign o_chan_idx = ev_word_ff[CRS_WORD_IDX_LSB +: CRS_IDX_W];
  assign o_chan_test = ev_word_ff[CRS_WORD_TEST_BIT];

endmodule : crs_readout_seq

`default_nettype wire

// ==== bench/crs_seq_props.sv ====
`default_nettype none

module crs_seq_props
  import crs_pkg::*;
#(
  parameter int NUM_CH = CRS_NUM_CH
)
(
  input wire logic i_mclk, // system clock
  input wire logic i_rst, // synchronous reset
  input wire logic i_logic_clear, // clear pin
  input wire logic i_sample_freeze, // freeze pin
  input wire logic i_token_inject, // token pin
  input wire logic i_shift_strobe, // shift clock pin
  input wire logic i_readout_strobe_compl, // shift clock complement
  input wire logic i_test_select, // test pin
  input wire logic i_chan_ready, // digitiser ready
  input wire logic [NUM_CH-1:0] o_out_sel, // output selects
  input wire logic [NUM_CH-1:0] o_cal_sel, // calibration selects
  input wire logic o_token_exit, // end token
  input wire logic o_sample_hold, // samples frozen
  input wire logic o_test_mode, // test mode
  input wire logic o_shift_stall, // shift waiting
  input wire logic o_chan_valid, // event valid
  input wire logic [CRS_IDX_W-1:0] o_chan_idx, // event channel
  input wire logic o_chan_test // event in test mode
);
  default clocking cb @(posedge i_mclk);
  endclocking
  default disable iff (i_rst);

  // shift clock idle long enough for any launched step to land
  sequence quiet_s;
    (!i_shift_strobe && !i_logic_clear && !o_shift_stall) [*7];
  endsequence
  sequence clr_s;
    i_logic_clear [*4];
  endsequence
  sequence test_s;
    (i_test_select && !i_logic_clear) [*4];
  endsequence
  sequence frz_s;
    (i_sample_freeze && !i_logic_clear) [*4];
  endsequence

  one_hot_a: assert property ($onehot0(o_out_sel))
    else $error("output select not one-hot");
  halt_keep_a: assert property (quiet_s |-> $stable(o_out_sel))
    else $error("selection moved with shift clock halted");
  cal_match_a: assert property (o_cal_sel != '0 |->
    o_cal_sel == o_out_sel)
    else $error("calibration select differs from output");
  token_step_a: assert property ($past(o_out_sel) != '0 &&
    o_out_sel != '0 && o_out_sel != $past(o_out_sel)
    |-> o_out_sel == ($past(o_out_sel) << 1))
    else $error("token did not step one channel down");
  token_load_a: assert property ($past(o_out_sel) == '0 &&
    o_out_sel != '0 |-> o_out_sel[0] && $onehot(o_out_sel))
    else $error("token not loaded into first stage");
  exit_rise_a: assert property ($rose(o_token_exit) |->
    $past(o_out_sel[NUM_CH-1]) && o_out_sel == '0)
    else $error("exit not raised from last stage");
  exit_empty_a: assert property (o_token_exit |-> o_out_sel == '0)
    else $error("channel selected while exit high");
  clear_all_a: assert property (clr_s |->
    o_out_sel == '0 && o_cal_sel == '0 && !o_token_exit)
    else $error("clear left readout state");
  test_on_a: assert property (test_s |-> o_test_mode)
    else $error("test mode not entered");
  cal_off_a: assert property (!o_test_mode |-> o_cal_sel == '0)
    else $error("calibration select outside test mode");
  hold_on_a: assert property (frz_s |-> o_sample_hold)
    else $error("samples not frozen after strobe");
endmodule : crs_seq_props

bind crs_readout_seq crs_seq_props #(.NUM_CH(NUM_CH)) u_props (
  .i_mclk, .i_rst, .i_logic_clear, .i_sample_freeze, .i_token_inject,
  .i_shift_strobe, .i_readout_strobe_compl, .i_test_select, .i_chan_ready,
  .o_out_sel, .o_cal_sel, .o_token_exit, .o_sample_hold, .o_test_mode,
  .o_shift_stall, .o_chan_valid, .o_chan_idx, .o_chan_test
);

`default_nettype wire

// ==== bench/crs_ctl_model.sv ====
`default_nettype none

module crs_ctl_model
  import crs_pkg::*;
(
  input wire logic i_mclk, // system clock
  input wire logic i_stall, // device stall flag
  input wire logic i_valid, // event word valid
  input wire logic [CRS_IDX_W-1:0] i_idx, // event channel
  input wire logic i_test, // event made in test mode
  output var logic o_freeze, // sample-hold strobe
  output var logic o_inject, // start token
  output var logic o_shift, // shift clock
  output logic o_shift_n, // shift clock complement
  output logic o_ready // digitiser ready
);
  timeunit 1ns;
  timeprecision 1ns;
  logic hold_off = 1'h0;
  int n_words = 0;
  int n_bad = 0;
  logic [CRS_IDX_W-1:0] exp_idx = 5'h00;
  logic exp_test = 1'h0;

  initial
  begin
    o_freeze = 1'h0;
    o_inject = 1'h0;
    o_shift = 1'h0;
  end
  assign o_shift_n = ~o_shift;
  assign o_ready = ~hold_off;

  // digitiser: words must come in channel order
  always @(posedge i_mclk)
  begin
    if (i_valid && o_ready)
    begin
      if (i_idx !== exp_idx || i_test !== exp_test)
        n_bad <= n_bad + 1;
      exp_idx <= exp_idx + 5'h01;
      n_words <= n_words + 1;
    end
  end

  task automatic edges(input int n);
    repeat (n) @(posedge i_mclk);
    #2;
  endtask : edges

  task automatic restart();
    n_words = 0;
    n_bad = 0;
    exp_idx = 5'h00;
    exp_test = 1'h0;
  endtask : restart

  // freeze lands the hold delay after the event
  task automatic freeze(input logic v);
    edges(v ? CRS_HOLD_DELAY_CYC : 1);
    o_freeze = v;
  endtask : freeze

  // pulse two clocks high, two low; optionally wait out a stall
  task automatic shift(input logic tok, input logic wait_sp);
    int t;
    t = 0;
    while (wait_sp && i_stall === 1'h1 && t < 400)
    begin
      edges(1);
      t++;
    end
    o_inject = tok;
    edges(1);
    o_shift = 1'h1;
    edges(2);
    o_shift = 1'h0;
    edges(2);
  endtask : shift
endmodule : crs_ctl_model

`default_nettype wire

// ==== bench/channel_readout_sequencer_tb.sv ====
`default_nettype none

module channel_readout_sequencer_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic i_mclk = 1'h0;
  logic i_rst = 1'h1;
  logic i_logic_clear = 1'h0;
  logic i_test_select = 1'h0;
  logic i_sample_freeze, i_token_inject, i_shift_strobe;
  logic i_readout_strobe_compl, i_chan_ready;
  logic [31:0] o_out_sel, o_cal_sel;
  logic o_token_exit, o_sample_hold, o_test_mode, o_shift_stall;
  logic o_chan_valid, o_chan_test;
  logic [4:0] o_chan_idx;
  int mismatches = 0;
  int n_compared = 0;

  always #25 i_mclk = ~i_mclk;

  crs_readout_seq u_dut (
    .i_mclk, .i_rst, .i_logic_clear, .i_sample_freeze, .i_token_inject,
    .i_shift_strobe, .i_readout_strobe_compl, .i_test_select, .i_chan_ready,
    .o_out_sel, .o_cal_sel, .o_token_exit, .o_sample_hold, .o_test_mode,
    .o_shift_stall, .o_chan_valid, .o_chan_idx, .o_chan_test
  );

  crs_ctl_model u_ctl (
    .i_mclk(i_mclk), .i_stall(o_shift_stall), .i_valid(o_chan_valid),
    .i_idx(o_chan_idx), .i_test(o_chan_test), .o_freeze(i_sample_freeze),
    .o_inject(i_token_inject), .o_shift(i_shift_strobe),
    .o_shift_n(i_readout_strobe_compl), .o_ready(i_chan_ready)
  );

  task automatic tick(input int n);
    repeat (n) @(posedge i_mclk);
    #2;
  endtask : tick

  task automatic check(input logic ok, input string msg);
    n_compared++;
    if (ok !== 1'h1)
    begin
      mismatches++;
      $display("BAD %0t %s", $time, msg);
    end
  endtask : check

  task automatic clear_pulse();
    i_logic_clear = 1'h1;
    tick(4);
    i_logic_clear = 1'h0;
  endtask : clear_pulse

  task automatic t_reset();
    check({o_out_sel, o_cal_sel, o_token_exit, o_test_mode, o_chan_valid}
      === 67'h0, "outputs after reset");
    $display("reset test done");
  endtask : t_reset

  // full pass; a second inject mid-pass must be ignored
  task automatic t_pass(input logic tm);
    logic [31:0] exp;
    i_test_select = tm;
    u_ctl.restart();
    u_ctl.exp_test = tm;
    tick(4);
    check(o_test_mode === tm, "test mode flag");
    u_ctl.freeze(1'h1);
    for (int k = 0; k < 34; k++)
    begin
      u_ctl.shift(k == 0 || k == 9, 1'h1);
      tick(3);
      exp = (k < 32) ? (32'h0000_0001 << k) : 32'h0000_0000;
      check(o_out_sel === exp, "token position");
      check(o_cal_sel === (tm ? exp : 32'h0), "cal select");
      check(o_token_exit === (k == 32), "exit level");
      if (k == 5)
      begin
        tick(40);
        check(o_out_sel === exp, "halted clock");
      end
    end
    check(u_ctl.n_words == 32 && u_ctl.n_bad == 0, "event words");
    check(o_sample_hold === 1'h1, "hold level");
    u_ctl.freeze(1'h0);
    tick(3);
    check(o_sample_hold === 1'h0, "hold released");
    $display("pass test done");
  endtask : t_pass

  task automatic t_clear();
    i_test_select = 1'h1;
    tick(4);
    u_ctl.shift(1'h1, 1'h1);
    u_ctl.shift(1'h0, 1'h1);
    tick(3);
    check(o_out_sel === 32'h0000_0002, "before clear");
    clear_pulse();
    tick(1);
    check({o_out_sel, o_cal_sel, o_token_exit} === 65'h0, "clear");
    tick(3);
    u_ctl.shift(1'h1, 1'h1);
    tick(3);
    check(o_out_sel === 32'h0000_0001, "reload");
    clear_pulse();
    i_test_select = 1'h0;
    tick(4);
    $display("clear test done");
  endtask : t_clear

  // digitiser stalls until the fifo refuses, then drains
  task automatic t_stall();
    int k;
    logic seen;
    u_ctl.restart();
    u_ctl.hold_off = 1'h1;
    seen = 1'h0;
    k = 0;
    while (!seen && k < 24)
    begin
      u_ctl.shift(k == 0, 1'h0);
      k++;
      tick(2);
      if (o_shift_stall === 1'h1)
        seen = 1'h1;
    end
    check(seen, "stall seen");
    u_ctl.hold_off = 1'h0;
    tick(80);
    check(o_shift_stall === 1'h0 && u_ctl.n_words == k
      && u_ctl.n_bad == 0, "drained");
    check(o_out_sel === (32'h0000_0001 << (k - 1)), "pending shift");
    clear_pulse();
    tick(4);
    $display("stall test done");
  endtask : t_stall

  task automatic close_out();
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : close_out

  initial
  begin
    repeat (6) @(posedge i_mclk);
    #2;
    i_rst = 1'h0;
    tick(1);
    t_reset();
    tick(3);
    t_pass(1'h0);
    t_pass(1'h1);
    t_clear();
    t_stall();
    close_out();
  end

  initial
  begin
    #400000;
    mismatches++;
    close_out();
  end
endmodule : channel_readout_sequencer_tb

`default_nettype wire
